// *** rtl/stepper_host_ctrl.sv ***
/*
  Host-side command block driver for a networked stepper indexer: issues
  reset-errors, run-assembled-move and preset-encoder blocks, and walks the
  assembled-move programming handshake over status word 0 bits 8 and 9.
  Assumes command words go out and status word 0 comes back on clk_sys,
  synchronous, with the network's cyclic copy handled elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
module stepper_host_ctrl
  import stepper_host_pkg::*;
#(
  parameter int WAIT_LIMIT = stepper_host_pkg::WAIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic opValid,
  output logic opReady,
  input wire stepper_host_pkg::op_e opKind,
  input wire logic clearDriverFaults,
  input wire logic dwellMode,
  input wire logic reverseBlend,
  input wire logic [15:0] dwellMs,
  input wire logic [23:0] presetValue,
  input wire logic [4:0] segCount,
  input wire logic segWrEn,
  input wire logic [3:0] segWrIdx,
  input wire stepper_host_pkg::segment_s segWrData,
  output logic segReject,
  input wire logic [15:0] statusWord0,
  output stepper_host_pkg::cmd_block_t cmdWords,
  output logic busy,
  output logic opDone,
  output logic opFail
);
  import stepper_host_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ONESHOT,
    ST_OPEN,
    ST_SEG_SEND,
    ST_SEG_RELEASE
  } state_e;

  function automatic logic segment_ok(input segment_s s);
    segment_ok = (s.speed <= SPEED_MAX)
      && (s.accel >= RAMP_MIN) && (s.accel <= RAMP_MAX)
      && (s.decel >= RAMP_MIN) && (s.decel <= RAMP_MAX)
      && !s.current[0]
      && (s.jerk <= JERK_MAX);
  endfunction : segment_ok

  // the 24-bit carriers make the signed step range impossible to exceed
  function automatic cmd_block_t segment_block(input cmd_block_t cur, input segment_s s);
    logic [31:0] target;
    target = {{8{s.relTarget[23]}}, s.relTarget};
    segment_block = cur;
    segment_block[WORD_CMD0] = CMD_PROG_SEGMENT;
    segment_block[WORD_VALUE_UP] = target[31:16];
    segment_block[WORD_VALUE_LO] = target[15:0];
    segment_block[WORD_SPEED_UP] = {10'h000, s.speed[21:16]};
    segment_block[WORD_SPEED_LO] = s.speed[15:0];
    segment_block[WORD_ACCEL] = s.accel;
    segment_block[WORD_DECEL] = s.decel;
    segment_block[WORD_CURRENT] = s.current;
    segment_block[WORD_JERK] = s.jerk;
  endfunction : segment_block

  state_e state_q, state_d;
  cmd_block_t cmd_q, cmd_d;
  logic [4:0] segTotal_q, segTotal_d;
  logic [4:0] segIdx_q, segIdx_d;
  logic [31:0] wait_q, wait_d;
  logic done_q, done_d;
  logic fail_q, fail_d;
  logic segReject_q;
  segment_s segRead;

  wire logic accept = opValid && (state_q == ST_IDLE);
  wire logic segWrGood = segWrEn && segment_ok(segWrData);
  wire logic inAsmMode = statusWord0[SW0_IN_ASSEMBLED_BIT];
  wire logic segWaiting = statusWord0[SW0_SEGMENT_WAIT_BIT];
  wire logic timedOut = (wait_q == 32'(WAIT_LIMIT - 1));
  wire logic holdOver = (wait_q == 32'(HOLD_CYCLES - 1));
  wire logic countBad = (segCount == 5'h00) || (segCount > 5'(MAX_SEGMENTS));
  wire logic lastSent = (segIdx_q == segTotal_q);
  wire logic [31:0] presetWide = {{8{presetValue[23]}}, presetValue};

  segment_store u_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrEn(segWrGood),
    .wrIdx(segWrIdx),
    .wrData(segWrData),
    // registered index: a read addressed by segIdx_d would loop back into the next-state logic
    .rdIdx(segIdx_q[3:0]),
    .rdData(segRead)
  );

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    segTotal_d = segTotal_q;
    segIdx_d = segIdx_q;
    wait_d = wait_q + 32'h00000001;
    done_d = 1'b0;
    fail_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        wait_d = 32'h00000000;
        segIdx_d = 5'h00;
        if (accept) begin
          // only the words each command uses are rewritten
          unique case (opKind)
            OP_RESET_ERRORS: begin
              cmd_d[WORD_CMD0] = CMD_RESET_ERRORS;
              cmd_d[WORD_CMD1][CW1_CLEAR_DRIVER_BIT] = clearDriverFaults;
              state_d = ST_ONESHOT;
            end
            OP_RUN_ASSEMBLED: begin
              cmd_d[WORD_CMD0] = CMD_RUN_ASSEMBLED;
              cmd_d[WORD_CMD1][CW1_DWELL_BIT] = dwellMode;
              cmd_d[WORD_CMD1][CW1_REVERSE_BLEND_BIT] = reverseBlend;
              if (dwellMode) begin
                cmd_d[WORD_JERK] = dwellMs;
              end
              state_d = ST_ONESHOT;
            end
            OP_PRESET_ENCODER: begin
              cmd_d[WORD_CMD0] = CMD_PRESET_ENCODER;
              cmd_d[WORD_VALUE_UP] = presetWide[31:16];
              cmd_d[WORD_VALUE_LO] = presetWide[15:0];
              state_d = ST_ONESHOT;
            end
            OP_PROGRAM: begin
              // a count the device cannot hold is refused rather than sent
              if (countBad) begin
                fail_d = 1'b1;
              end else begin
                cmd_d[WORD_CMD0] = CMD_PROG_FIRST;
                segTotal_d = segCount;
                state_d = ST_OPEN;
              end
            end
          endcase
        end
      end
      ST_ONESHOT: begin
        if (holdOver) begin
          cmd_d[WORD_CMD0] = CMD_IDLE;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_OPEN: begin
        if (inAsmMode && segWaiting) begin
          cmd_d = segment_block(cmd_q, segRead);
          wait_d = 32'h00000000;
          state_d = ST_SEG_SEND;
        end
      end
      ST_SEG_SEND: begin
        if (!segWaiting) begin
          cmd_d[WORD_CMD0] = CMD_PROG_FIRST;
          segIdx_d = segIdx_q + 5'h01;
          wait_d = 32'h00000000;
          state_d = ST_SEG_RELEASE;
        end
      end
      ST_SEG_RELEASE: begin
        if (segWaiting) begin
          wait_d = 32'h00000000;
          if (lastSent) begin
            cmd_d[WORD_CMD0] = CMD_IDLE;
            done_d = 1'b1;
            state_d = ST_IDLE;
          end else begin
            cmd_d = segment_block(cmd_q, segRead);
            state_d = ST_SEG_SEND;
          end
        end
      end
    endcase
    // a device that stops answering must not hang the host forever
    if (state_q != ST_IDLE && state_q != ST_ONESHOT && timedOut) begin
      cmd_d[WORD_CMD0] = CMD_IDLE;
      fail_d = 1'b1;
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      segTotal_q <= 5'h00;
      segIdx_q <= 5'h00;
      wait_q <= 32'h00000000;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      segReject_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      segTotal_q <= segTotal_d;
      segIdx_q <= segIdx_d;
      wait_q <= wait_d;
      done_q <= done_d;
      fail_q <= fail_d;
      segReject_q <= segWrEn && !segWrGood;
    end
  end

  assign opReady = (state_q == ST_IDLE);
  assign busy = (state_q != ST_IDLE);
  assign cmdWords = cmd_q;
  assign opDone = done_q;
  assign opFail = fail_q;
  assign segReject = segReject_q;

  wire logic [31:0] valueWord = {cmd_q[WORD_VALUE_UP], cmd_q[WORD_VALUE_LO]};

  resetCmd_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opKind == OP_RESET_ERRORS |=> cmd_q[WORD_CMD0] == CMD_RESET_ERRORS)
    else $error("reset errors code not issued");
  driverClear_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opKind == OP_RESET_ERRORS
      |=> cmd_q[WORD_CMD1][CW1_CLEAR_DRIVER_BIT] == $past(clearDriverFaults))
    else $error("driver fault clear bit wrong");
  runBits_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opKind == OP_RUN_ASSEMBLED |=> cmd_q[WORD_CMD0] == CMD_RUN_ASSEMBLED
      && cmd_q[WORD_CMD1][CW1_DWELL_BIT] == $past(dwellMode)
      && cmd_q[WORD_CMD1][CW1_REVERSE_BLEND_BIT] == $past(reverseBlend))
    else $error("run assembled block wrong");
  dwellTime_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opKind == OP_RUN_ASSEMBLED && dwellMode |=> cmd_q[WORD_JERK] == $past(dwellMs))
    else $error("dwell time not placed in word 9");
  presetRange_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_q[WORD_CMD0] == CMD_PRESET_ENCODER
      |-> $signed(valueWord) >= -32'sd8388608 && $signed(valueWord) <= 32'sd8388607)
    else $error("encoder preset out of range");
  firstBlock_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_OPEN |-> cmd_q[WORD_CMD0] == CMD_PROG_FIRST)
    else $error("first programming block code wrong");
  segGate_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(cmd_q[WORD_CMD0][CW0_SEGMENT_BIT]) |-> $past(inAsmMode && segWaiting))
    else $error("segment sent before device ready");
  segCode_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SEG_SEND |-> cmd_q[WORD_CMD0] == CMD_PROG_SEGMENT)
    else $error("segment block code wrong");
  segRelease_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SEG_SEND && !segWaiting |=> !cmd_q[WORD_CMD0][CW0_SEGMENT_BIT]
      && cmd_q[WORD_CMD0] == CMD_PROG_FIRST)
    else $error("bit 12 not released after status bit 9 cleared");
  nextSeg_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SEG_RELEASE && !segWaiting && !timedOut |=> state_q == ST_SEG_RELEASE)
    else $error("next segment sent before status bit 9 set");
  segLimit_a: assert property (@(posedge clk_sys) disable iff (rst)
    segIdx_q <= 5'(MAX_SEGMENTS) && segIdx_q <= segTotal_q)
    else $error("segment count beyond limit");
  segFields_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SEG_SEND |-> cmd_q[WORD_ACCEL] >= RAMP_MIN
      && cmd_q[WORD_ACCEL] <= RAMP_MAX && !cmd_q[WORD_CURRENT][0]
      && cmd_q[WORD_JERK] <= JERK_MAX)
    else $error("segment fields out of range");
  oneShotEnd_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_ONESHOT && holdOver |=> opDone && cmd_q[WORD_CMD0] == CMD_IDLE)
    else $error("one-shot command not released");

  programDone_c: cover property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SEG_RELEASE && segWaiting && lastSent);
  fullProgram_c: cover property (@(posedge clk_sys) disable iff (rst)
    segTotal_q == 5'(MAX_SEGMENTS) && opDone);
  dwellRun_c: cover property (@(posedge clk_sys) disable iff (rst)
    accept && opKind == OP_RUN_ASSEMBLED && dwellMode);
  waitTimeout_c: cover property (@(posedge clk_sys) disable iff (rst) opFail && $past(busy));

endmodule : stepper_host_ctrl
`default_nettype wire

// *** pkg/stepper_host_pkg.sv ***
/*
  Shared constants and types for the host-side controller of a networked
  stepper indexer: command codes, bit positions, field limits, timing and
  the segment and command block carriers.
  Assumes the indexer exchanges ten 16-bit command words and reads back
  status word 0 each network cycle, with 32-bit values in upper/lower words.
*/
package stepper_host_pkg;

  localparam int WORDS = 10;
  localparam logic [15:0] CMD_IDLE = 16'h0000;
  localparam logic [15:0] CMD_RESET_ERRORS = 16'h0400;
  localparam logic [15:0] CMD_RUN_ASSEMBLED = 16'h2000;
  localparam logic [15:0] CMD_PRESET_ENCODER = 16'h4000;
  localparam logic [15:0] CMD_PROG_FIRST = 16'h0800;
  localparam logic [15:0] CMD_PROG_SEGMENT = 16'h1800;

  // command word 0 / 1 and status word 0 bit positions
  localparam int CW0_SEGMENT_BIT = 12;
  localparam int CW1_CLEAR_DRIVER_BIT = 10;
  localparam int CW1_DWELL_BIT = 9;
  localparam int CW1_REVERSE_BLEND_BIT = 4;
  localparam int SW0_IN_ASSEMBLED_BIT = 8;
  localparam int SW0_SEGMENT_WAIT_BIT = 9;

  // command block word indices
  localparam int WORD_CMD0 = 0;
  localparam int WORD_CMD1 = 1;
  localparam int WORD_VALUE_UP = 2;
  localparam int WORD_VALUE_LO = 3;
  localparam int WORD_SPEED_UP = 4;
  localparam int WORD_SPEED_LO = 5;
  localparam int WORD_ACCEL = 6;
  localparam int WORD_DECEL = 7;
  localparam int WORD_CURRENT = 8;
  localparam int WORD_JERK = 9;

  localparam int MAX_SEGMENTS = 16;
  localparam logic [15:0] RAMP_MIN = 16'h0001;
  localparam logic [15:0] RAMP_MAX = 16'h1388;
  localparam logic [15:0] JERK_MAX = 16'h1388;
  localparam logic [21:0] SPEED_MAX = 22'h2DC6BF;
  localparam logic [23:0] POS_MIN = 24'h800000;
  localparam logic [23:0] POS_MAX = 24'h7FFFFF;

  // one-shot commands are held this long before word 0 returns to idle
  localparam int HOLD_CYCLES = 4;
  localparam int CLK_MHZ = 200;
  localparam int WAIT_TIME_US = 1000;
  localparam int WAIT_CYCLES = WAIT_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    OP_RESET_ERRORS,
    OP_RUN_ASSEMBLED,
    OP_PRESET_ENCODER,
    OP_PROGRAM
  } op_e;

  typedef struct packed {
    logic [23:0] relTarget;
    logic [21:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] current;
    logic [15:0] jerk;
  } segment_s;

  typedef logic [WORDS-1:0][15:0] cmd_block_t;

endpackage : stepper_host_pkg

// *** rtl/segment_store.sv ***
/*
  Sixteen-entry segment table for the host controller. Written by the user
  one validated segment at a time, read combinationally by index.
  Assumes the writer has already screened each segment's field ranges.
*/
`timescale 1ns/1ps
`default_nettype none
module segment_store
  import stepper_host_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire stepper_host_pkg::segment_s wrData,
  input wire logic [3:0] rdIdx,
  output stepper_host_pkg::segment_s rdData
);
  import stepper_host_pkg::*;

  segment_s table_q [MAX_SEGMENTS];

  // contents need no reset: a program only reads entries written before it
  always_ff @(posedge clk_sys) begin
    if (wrEn && !rst) begin
      table_q[wrIdx] <= wrData;
    end
  end

  assign rdData = table_q[rdIdx];

endmodule : segment_store
`default_nettype wire

// *** dv/indexer_model.sv ***
/*
  Behavioural model of the indexer's command side: status word 0 bits 8, 9
  and the error flags, answering after lat cycles, or never while mute.
  Assumes the host registers its command words on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module indexer_model
  import stepper_host_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire stepper_host_pkg::cmd_block_t cmdWords,
  input wire logic [3:0] lat,
  input wire logic mute,
  output logic [15:0] statusWord0
);
  import stepper_host_pkg::*;

  logic [15:0] w0;
  logic go;
  logic drvFault;
  logic [3:0] dly;
  logic [4:0] segs;
  cmd_block_t mem [MAX_SEGMENTS];
  assign w0 = cmdWords[WORD_CMD0];
  // bit 12 waits for bit 9 up; bit 11 alone waits for bit 9 down
  assign go = w0[CW0_SEGMENT_BIT] ? statusWord0[9] : (w0[11] && !statusWord0[9]);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      statusWord0 <= 16'h0000;
      dly <= 4'h0;
      segs <= 5'h00;
      drvFault <= 1'b1;
    end else if (!mute) begin
      if (w0 == CMD_RESET_ERRORS) begin
        statusWord0[12:11] <= 2'b00;
        statusWord0[7] <= 1'b0;
        if (cmdWords[WORD_CMD1][CW1_CLEAR_DRIVER_BIT]) drvFault <= 1'b0;
      end
      if (w0 == CMD_IDLE) statusWord0[9:8] <= 2'b00;
      if (w0[CW0_SEGMENT_BIT] && !statusWord0[8]) statusWord0[12] <= 1'b1;
      if (go && dly != lat) dly <= dly + 4'h1;
      else if (go) begin
        dly <= 4'h0;
        if (!w0[CW0_SEGMENT_BIT]) begin
          statusWord0[9:8] <= 2'b11;
          if (!statusWord0[8]) segs <= 5'h00;
        end else if (segs == 5'(MAX_SEGMENTS)) statusWord0[12] <= 1'b1;
        else begin
          mem[segs[3:0]] <= cmdWords;
          segs <= segs + 5'h01;
          statusWord0[9] <= 1'b0;
        end
      end else dly <= 4'h0;
    end
  end
endmodule : indexer_model
`default_nettype wire

// *** dv/stepper_command_block_handler_test.sv ***
/*
  Self-checking bench for stepper_host_ctrl facing indexer_model.
  Assumes the design package and modules are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module stepper_command_block_handler_test;
  import stepper_host_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, opValid = 1'b0, clearDriverFaults = 1'b0;
  logic dwellMode = 1'b0, reverseBlend = 1'b0, segWrEn = 1'b0, mute = 1'b0;
  op_e opKind = OP_RESET_ERRORS;
  logic [15:0] dwellMs = 16'h0000, statusWord0;
  logic [23:0] presetValue = 24'h000000;
  logic [4:0] segCount = 5'h00;
  logic [3:0] segWrIdx = 4'h0, lat = 4'h0;
  segment_s segWrData = '0;
  cmd_block_t cmdWords, prevBlk = '0, expBlk = '0;
  logic opReady, segReject, busy, opDone, opFail;
  cmd_block_t expQ[$];
  logic [2:0] flagQ[$];
  segment_s tbl[16];
  int n_mismatch = 0, compares = 0, seed = 32'h1c14;

  initial forever #2.5 clk_sys = ~clk_sys;

  stepper_host_ctrl #(.WAIT_LIMIT(50)) u_stepper_host_ctrl (.clk_sys(clk_sys), .rst(rst),
    .opValid(opValid), .opReady(opReady), .opKind(opKind),
    .clearDriverFaults(clearDriverFaults), .dwellMode(dwellMode), .reverseBlend(reverseBlend),
    .dwellMs(dwellMs), .presetValue(presetValue), .segCount(segCount), .segWrEn(segWrEn),
    .segWrIdx(segWrIdx), .segWrData(segWrData), .segReject(segReject),
    .statusWord0(statusWord0), .cmdWords(cmdWords), .busy(busy), .opDone(opDone),
    .opFail(opFail));
  indexer_model u_indexer_model (.clk_sys(clk_sys), .rst(rst), .cmdWords(cmdWords),
    .lat(lat), .mute(mute), .statusWord0(statusWord0));

  task automatic check(input logic [159:0] seen, input logic [159:0] expv);
    compares++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic results();
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // every change of the block and every result pulse must match the oldest note
  always @(posedge clk_sys) begin
    prevBlk <= cmdWords;
    if (!rst && cmdWords !== prevBlk)
      check(cmdWords, expQ.size() ? expQ.pop_front() : ~cmdWords);
    if (!rst && (opDone === 1'b1 || opFail === 1'b1 || segReject === 1'b1))
      check(160'({opDone, opFail, segReject, busy, opReady}),
        160'({(flagQ.size() ? flagQ.pop_front() : 3'h0), 2'b01}));
  end

  function automatic void push(input logic [15:0] w0);
    expBlk[0] = w0;
    expQ.push_back(expBlk);
  endfunction : push

  task automatic op(input op_e k, input logic [2:0] fl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (opReady !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      n_mismatch++;
      results();
    end
    opValid <= 1'b1;
    opKind <= k;
    flagQ.push_back(fl);
    @(posedge clk_sys);
    opValid <= 1'b0;
  endtask : op

  task automatic drain();
    int n;
    n = 0;
    while ((expQ.size() != 0 || flagQ.size() != 0) && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      results();
    end
  endtask : drain

  task automatic wrSeg(input logic [3:0] idx, input segment_s d, input logic bad);
    @(posedge clk_sys);
    segWrEn <= 1'b1;
    segWrIdx <= idx;
    segWrData <= d;
    @(posedge clk_sys);
    segWrEn <= 1'b0;
    if (bad) flagQ.push_back(3'b001);
  endtask : wrSeg

  task automatic prog(input int n);
    segCount <= 5'(n);
    push(CMD_PROG_FIRST);
    for (int i = 0; i < n; i++) begin
      expBlk[2] = {{8{tbl[i].relTarget[23]}}, tbl[i].relTarget[23:16]};
      expBlk[3] = tbl[i].relTarget[15:0];
      expBlk[4] = {10'h000, tbl[i].speed[21:16]};
      expBlk[5] = tbl[i].speed[15:0];
      expBlk[6] = tbl[i].accel;
      expBlk[7] = tbl[i].decel;
      expBlk[8] = tbl[i].current;
      expBlk[9] = tbl[i].jerk;
      push(CMD_PROG_SEGMENT);
      push(CMD_PROG_FIRST);
    end
    push(CMD_IDLE);
    op(OP_PROGRAM, 3'b100);
  endtask : prog

  initial begin
    segment_s s;
    logic [15:0] v;
    logic [23:0] p;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(160'({opReady, busy, opDone, opFail, segReject}), 160'(5'b10000));
    for (int i = 0; i < 16; i++) begin
      tbl[i].relTarget = 24'($random(seed));
      tbl[i].speed = 22'($unsigned($random(seed)) % 3000000);
      tbl[i].accel = 16'($unsigned($random(seed)) % 5000 + 1);
      tbl[i].decel = 16'($unsigned($random(seed)) % 5000 + 1);
      tbl[i].current = 16'($random(seed)) & 16'h00FE;
      tbl[i].jerk = 16'($unsigned($random(seed)) % 5001);
      if (i == 0) tbl[i] = '{POS_MIN, SPEED_MAX, RAMP_MAX, RAMP_MIN, 16'h003C, JERK_MAX};
      wrSeg(4'(i), tbl[i], 1'b0);
    end
    // rejected writes at index 0 must leave the boundary segment in place
    for (int f = 0; f < 6; f++) begin
      s = tbl[0];
      case (f)
        0: s.speed = SPEED_MAX + 22'h000001;
        1: s.accel = 16'h0000;
        2: s.decel = RAMP_MAX + 16'h0001;
        3: s.current = tbl[0].current | 16'h0001;
        4: s.jerk = JERK_MAX + 16'h0001;
        default: s.accel = RAMP_MAX + 16'h0001;
      endcase
      wrSeg(4'h0, s, 1'b1);
    end
    for (int i = 0; i < 2; i++) begin
      clearDriverFaults <= i[0];
      expBlk[1][CW1_CLEAR_DRIVER_BIT] = i[0];
      push(CMD_RESET_ERRORS);
      push(CMD_IDLE);
      op(OP_RESET_ERRORS, 3'b100);
    end
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      dwellMode <= i[0];
      reverseBlend <= i[1];
      dwellMs <= v;
      if (i[0]) expBlk[9] = v;
      expBlk[1][CW1_DWELL_BIT] = i[0];
      expBlk[1][CW1_REVERSE_BLEND_BIT] = i[1];
      push(CMD_RUN_ASSEMBLED);
      push(CMD_IDLE);
      op(OP_RUN_ASSEMBLED, 3'b100);
    end
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? POS_MIN : (i == 1) ? POS_MAX : 24'($random(seed));
      presetValue <= p;
      {expBlk[2], expBlk[3]} = {{8{p[23]}}, p};
      push(CMD_PRESET_ENCODER);
      push(CMD_IDLE);
      op(OP_PRESET_ENCODER, 3'b100);
    end
    segCount <= 5'h00;
    op(OP_PROGRAM, 3'b010);
    segCount <= 5'h11;
    op(OP_PROGRAM, 3'b010);
    prog(1);
    lat <= 4'hA;
    prog(16);
    drain();
    lat <= 4'($unsigned($random(seed)) % 11);
    prog(16);
    drain();
    // a silent indexer must end in a refusal, not a hang
    mute <= 1'b1;
    segCount <= 5'h01;
    push(CMD_PROG_FIRST);
    push(CMD_IDLE);
    op(OP_PROGRAM, 3'b010);
    drain();
    mute <= 1'b0;
    prog(2);
    drain();
    results();
  end
endmodule : stepper_command_block_handler_test
`default_nettype wire
